// file: txlt_map.svh
// Register indices, field positions and reset values of the tx length block
`ifndef TXLT_MAP_SVH
`define TXLT_MAP_SVH

// Register indices; byte address is four times the index
`define TXLT_IDX_CNT_HI      6'h1D
`define TXLT_IDX_CNT_LO      6'h1E
`define TXLT_IDX_RATE        6'h1F
`define TXLT_IDX_ADC         6'h20
`define TXLT_IDX_TUNE        6'h21
`define TXLT_IDX_IRQ_STATUS  6'h26
`define TXLT_IDX_IRQ_ENABLE  6'h27
`define TXLT_IDX_IRQ_CLEAR   6'h28

// Byte address to word index
`define TXLT_ADDR_IDX_MSB    7
`define TXLT_ADDR_IDX_LSB    2

// Field positions in the low-count register
`define TXLT_LO_CNT_MSB      7
`define TXLT_LO_CNT_LSB      3
`define TXLT_LO_SPLIT_MSB    2
`define TXLT_LO_SPLIT_LSB    0
`define TXLT_SPLIT_NONE      3'h0

// Field positions in the rate display register
`define TXLT_RATE_MSB        7
`define TXLT_RATE_LSB        4
`define TXLT_RATE_PAD        4'h0

// Field positions in the antenna tuning control register
`define TXLT_TUNE_SEL_BIT    7
`define TXLT_TUNE_MAN_MSB    6
`define TXLT_TUNE_MAN_LSB    3
`define TXLT_TUNE_RSV_ZERO   3'h0

// Positions inside the stored five-bit tuning field
`define TXLT_TUNE_SEL_POS    4
`define TXLT_TUNE_FLD_MSB    3
`define TXLT_TUNE_FLD_LSB    0

// Interrupt bit positions
`define TXLT_IRQ_TX_START    0
`define TXLT_IRQ_PARITY      1
`define TXLT_IRQ_ADC         2
`define TXLT_IRQ_CAL         3
`define TXLT_IRQ_PAD         28'h0000000

// Reset values
`define TXLT_RST_BYTE        8'h00
`define TXLT_RST_TUNE        5'h00
`define TXLT_RST_IRQ         4'h0
`define TXLT_RST_WORD        32'h00000000
`define TXLT_BYTE_PAD        24'h000000

`endif

// file: txlt_pkg.sv
// Types shared by the tx length and antenna trim register block
package txlt_pkg;

  typedef enum logic [0:0] {
    TXLT_BUS_IDLE,
    TXLT_BUS_ANSWER
  } txlt_bus_state_type;

  typedef struct packed {
    txlt_bus_state_type bus_st;
    logic               wait_req;
    logic [31:0]        rdata;
    logic [7:0]         cnt_hi;
    logic [7:0]         cnt_lo;
    logic [4:0]         tune;
    logic [3:0]         irq_status;
    logic [3:0]         irq_enable;
    logic [12:0]        tx_count;
    logic [2:0]         tx_split;
    logic               tx_no_parity;
    logic               tx_bit_frame;
    logic               par_err;
    logic [3:0]         trim;
    logic               irq;
  } txlt_state_type;

endpackage

// file: txlt_capture_reg.sv
// Read-only result latch, loaded by a pulse and cleared by restore defaults
`timescale 1ns/100ps
module txlt_capture_reg #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_reset,
  // Control
  input  wire logic             i_clear,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_data,
  // Result
  output logic      [WIDTH-1:0] o_value
);

  typedef struct packed {
    logic [WIDTH-1:0] value;
  } txlt_cap_state_type;

  txlt_cap_state_type s_q;
  txlt_cap_state_type s_d;

  // Restore defaults wins over a result arriving in the same cycle
  always_comb begin
    s_d = s_q;
    if (i_clear) begin
      s_d.value = '0;
    end else if (i_load) begin
      s_d.value = i_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_value = s_q.value;

endmodule

// file: txlt_regs.sv
// Transmit length, bit rate, conversion result and antenna trim registers
//
// What this block does
// RULE1: Thirteen-bit full-byte count across two registers.
// RULE2: Software keeps byte count at most 8191.
// RULE3: Low three bits give split-byte bit count.
// RULE4: Split byte in 14443A: bit frame, no parity.
// RULE5: Count and trim registers clear on defaults.
// RULE6: Rate and conversion displays clear on defaults.
// RULE7: Detected rate code sits in bits 7:4.
// RULE8: WUPA with split bits raises parity error; raised only with anticollision enabled and card idle.
// RULE9: Last conversion result readable, read-only.
// RULE10: Select bit picks calibration or manual trim.
// RULE11: Manual trim bits drive both pin groups.
// RULE12: Calibration result held, drives trim otherwise.
// RULE13: Counts sampled at transmit start only.
`timescale 1ns/100ps
`include "txlt_map.svh"
module txlt_regs (
  // Clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // Avalon-MM slave
  input  wire logic [7:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [3:0]  i_avs_byteenable,
  input  wire logic [31:0] i_avs_writedata,
  output logic      [31:0] o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Command and mode inputs from the core
  input  wire logic        i_set_default,
  input  wire logic        i_tx_start,
  input  wire logic        i_iso14443a_mode,
  input  wire logic        i_anticoll_enable,
  input  wire logic        i_card_idle,
  input  wire logic        i_wupa_cmd,
  // Result inputs from the core
  input  wire logic        i_rate_valid,
  input  wire logic [3:0]  i_rate_code,
  input  wire logic        i_adc_valid,
  input  wire logic [7:0]  i_adc_data,
  input  wire logic        i_cal_valid,
  input  wire logic [3:0]  i_cal_trim,
  // Transmit parameters for the framer
  output logic      [12:0] o_tx_byte_count,
  output logic      [2:0]  o_tx_split_bits,
  output logic             o_tx_no_parity,
  output logic             o_tx_bit_frame,
  // Parity error event
  output logic             o_parity_err,
  // LC trim switches
  output logic      [3:0]  o_trim1,
  output logic      [3:0]  o_trim2,
  // Interrupt
  output logic             o_irq
);

  txlt_pkg::txlt_state_type s_q;
  txlt_pkg::txlt_state_type s_d;

  logic [5:0]  reg_idx;
  logic [3:0]  rate_value;
  logic [7:0]  adc_value;
  logic [3:0]  cal_value;
  logic [31:0] read_mux;
  logic [3:0]  irq_set;
  logic [3:0]  irq_clr;
  logic        wr_commit;
  logic        split_present;
  logic        wupa_par_err;
  // Write strobes, one per writable register
  logic        wr_cnt_hi;
  logic        wr_cnt_lo;
  logic        wr_tune;
  logic        wr_irq_enable;
  logic        wr_irq_clear;
  // Next bus handshake state and answer
  txlt_pkg::txlt_bus_state_type bus_next;
  logic        wait_next;
  logic [31:0] rdata_next;
  // Next transmit snapshot, taken only at a start
  logic [12:0] snap_count;
  logic [2:0]  snap_split;
  logic        snap_bit_frame;
  // Next tuning control, trim drive and interrupt state
  logic [4:0]  tune_next;
  logic [3:0]  trim_next;
  logic [3:0]  enable_next;
  logic [3:0]  irq_status_next;
  logic        irq_next;

  assign reg_idx = i_avs_address[`TXLT_ADDR_IDX_MSB:`TXLT_ADDR_IDX_LSB];

  // RULE3: split-byte bit count
  assign split_present =
    s_q.cnt_lo[`TXLT_LO_SPLIT_MSB:`TXLT_LO_SPLIT_LSB] != `TXLT_SPLIT_NONE;

  // RULE8: WUPA parity error
  assign wupa_par_err = i_wupa_cmd && i_anticoll_enable && i_card_idle
                        && split_present;

  // RULE7: detected rate display
  txlt_capture_reg #(
    .WIDTH (4)
  ) u_rate (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (i_set_default),
    .i_load  (i_rate_valid),
    .i_data  (i_rate_code),
    .o_value (rate_value)
  );

  // RULE9: conversion result latch
  txlt_capture_reg #(
    .WIDTH (8)
  ) u_adc (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (i_set_default),
    .i_load  (i_adc_valid),
    .i_data  (i_adc_data),
    .o_value (adc_value)
  );

  // RULE12: calibration result latch
  txlt_capture_reg #(
    .WIDTH (4)
  ) u_cal (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_clear (i_set_default),
    .i_load  (i_cal_valid),
    .i_data  (i_cal_trim),
    .o_value (cal_value)
  );

  // Read data; unused and reserved bits read as zero
  always_comb begin
    read_mux = `TXLT_RST_WORD;
    if (reg_idx == `TXLT_IDX_CNT_HI) begin
      read_mux = {`TXLT_BYTE_PAD, s_q.cnt_hi};
    end else if (reg_idx == `TXLT_IDX_CNT_LO) begin
      read_mux = {`TXLT_BYTE_PAD, s_q.cnt_lo};
    end else if (reg_idx == `TXLT_IDX_RATE) begin
      // RULE7: code in upper nibble
      read_mux = {`TXLT_BYTE_PAD, rate_value, `TXLT_RATE_PAD};
    end else if (reg_idx == `TXLT_IDX_ADC) begin
      // RULE9: display reads back
      read_mux = {`TXLT_BYTE_PAD, adc_value};
    end else if (reg_idx == `TXLT_IDX_TUNE) begin
      read_mux = {`TXLT_BYTE_PAD, s_q.tune, `TXLT_TUNE_RSV_ZERO};
    end else if (reg_idx == `TXLT_IDX_IRQ_STATUS) begin
      read_mux = {`TXLT_IRQ_PAD, s_q.irq_status};
    end else if (reg_idx == `TXLT_IDX_IRQ_ENABLE) begin
      read_mux = {`TXLT_IRQ_PAD, s_q.irq_enable};
    end else begin
      read_mux = `TXLT_RST_WORD;
    end
  end

  // A write lands at the edge where waitrequest is sampled low
  assign wr_commit = (s_q.bus_st == txlt_pkg::TXLT_BUS_ANSWER)
                     && i_avs_write && i_avs_byteenable[0];

  // Interrupt sources
  always_comb begin
    irq_set = `TXLT_RST_IRQ;
    irq_set[`TXLT_IRQ_TX_START] = i_tx_start;
    irq_set[`TXLT_IRQ_PARITY]   = wupa_par_err;
    irq_set[`TXLT_IRQ_ADC]      = i_adc_valid;
    irq_set[`TXLT_IRQ_CAL]      = i_cal_valid;
  end

  always_comb begin
    irq_clr = `TXLT_RST_IRQ;
    if (wr_irq_clear) begin
      irq_clr = i_avs_writedata[3:0];
    end
  end

  // Write strobes; the chain keeps them one-hot, and all of them wait for
  // the committing edge so nothing lands while waitrequest is high
  always_comb begin
    wr_cnt_hi     = 1'b0;
    wr_cnt_lo     = 1'b0;
    wr_tune       = 1'b0;
    wr_irq_enable = 1'b0;
    wr_irq_clear  = 1'b0;
    if (!wr_commit) begin
      wr_cnt_hi = 1'b0;
    end else if (reg_idx == `TXLT_IDX_CNT_HI) begin
      // RULE1: count bits 12 to 5
      wr_cnt_hi = 1'b1;
    end else if (reg_idx == `TXLT_IDX_CNT_LO) begin
      // RULE1: count bits 4 to 0
      wr_cnt_lo = 1'b1;
    end else if (reg_idx == `TXLT_IDX_TUNE) begin
      // RULE10: select and manual bits
      wr_tune = 1'b1;
    end else if (reg_idx == `TXLT_IDX_IRQ_ENABLE) begin
      wr_irq_enable = 1'b1;
    end else if (reg_idx == `TXLT_IDX_IRQ_CLEAR) begin
      wr_irq_clear = 1'b1;
    end else begin
      // Read-only and unmapped indices ignore writes
      wr_cnt_hi = 1'b0;
    end
  end

  // Bus handshake: one cycle of wait, then one cycle of answer; the
  // answer state always returns to idle so waitrequest is low one cycle
  always_comb begin
    bus_next   = s_q.bus_st;
    wait_next  = s_q.wait_req;
    rdata_next = s_q.rdata;
    case (s_q.bus_st)
      txlt_pkg::TXLT_BUS_IDLE: begin
        if (i_avs_read || i_avs_write) begin
          bus_next   = txlt_pkg::TXLT_BUS_ANSWER;
          wait_next  = 1'b0;
          rdata_next = i_avs_read ? read_mux : `TXLT_RST_WORD;
        end
      end
      txlt_pkg::TXLT_BUS_ANSWER: begin
        bus_next  = txlt_pkg::TXLT_BUS_IDLE;
        wait_next = 1'b1;
      end
      default: begin
        bus_next  = txlt_pkg::TXLT_BUS_IDLE;
        wait_next = 1'b1;
      end
    endcase
  end

  // Tuning control as it stands after this edge
  always_comb begin
    tune_next = s_q.tune;
    if (wr_tune) begin
      tune_next = i_avs_writedata[`TXLT_TUNE_SEL_BIT:`TXLT_TUNE_MAN_LSB];
    end
    // RULE5: defaults clear trim control
    if (i_set_default) begin
      tune_next = `TXLT_RST_TUNE;
    end
  end

  // RULE10: trim source select; the select written at this edge acts at
  // once, so the switches never show a stale source for a cycle
  always_comb begin
    if (tune_next[`TXLT_TUNE_SEL_POS]) begin
      // RULE11: manual bits, MSB first
      trim_next = tune_next[`TXLT_TUNE_FLD_MSB:`TXLT_TUNE_FLD_LSB];
    end else begin
      // RULE12: calibration result drives
      trim_next = cal_value;
    end
  end

  // RULE13: snapshot of the registers as they stood before the start
  // edge, so a write landing on that edge only reaches the next one
  always_comb begin
    // RULE1: assemble the full count
    snap_count = {s_q.cnt_hi,
                  s_q.cnt_lo[`TXLT_LO_CNT_MSB:`TXLT_LO_CNT_LSB]};
    // RULE3: trailing split-byte bits
    snap_split = s_q.cnt_lo[`TXLT_LO_SPLIT_MSB:`TXLT_LO_SPLIT_LSB];
    // RULE4: bit frame with split byte
    snap_bit_frame = i_iso14443a_mode && split_present;
  end

  // Interrupt enables change only by a committed write
  always_comb begin
    enable_next = s_q.irq_enable;
    if (wr_irq_enable) begin
      enable_next = i_avs_writedata[3:0];
    end
  end

  // Set wins over clear so an event is never lost; the interrupt follows
  // the next status at once, so it drops in the cycle the clear lands
  always_comb begin
    irq_status_next = (s_q.irq_status & ~irq_clr) | irq_set;
    irq_next        = |(irq_status_next & enable_next);
  end

  // Register image for the next edge
  always_comb begin
    s_d = s_q;
    s_d.par_err  = wupa_par_err;
    s_d.bus_st   = bus_next;
    s_d.wait_req = wait_next;
    s_d.rdata    = rdata_next;

    // Only the low byte lane carries register data
    if (wr_cnt_hi) begin
      s_d.cnt_hi = i_avs_writedata[7:0];
    end
    if (wr_cnt_lo) begin
      s_d.cnt_lo = i_avs_writedata[7:0];
    end

    // RULE5: restore defaults beats a write
    if (i_set_default) begin
      s_d.cnt_hi = `TXLT_RST_BYTE;
      s_d.cnt_lo = `TXLT_RST_BYTE;
    end
    s_d.tune = tune_next;

    // RULE13: sample at transmit start
    if (i_tx_start) begin
      s_d.tx_count     = snap_count;
      s_d.tx_split     = snap_split;
      s_d.tx_bit_frame = snap_bit_frame;
      // RULE4: no parity with bit frame
      s_d.tx_no_parity = snap_bit_frame;
    end

    s_d.irq_status = irq_status_next;
    s_d.irq_enable = enable_next;
    s_d.irq        = irq_next;
    s_d.trim       = trim_next;
  end

  // Waitrequest stays high in reset so no access is taken early
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      s_q          <= '0;
      s_q.wait_req <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_avs_readdata    = s_q.rdata;
  assign o_avs_waitrequest = s_q.wait_req;
  assign o_tx_byte_count   = s_q.tx_count;
  assign o_tx_split_bits   = s_q.tx_split;
  assign o_tx_no_parity    = s_q.tx_no_parity;
  assign o_tx_bit_frame    = s_q.tx_bit_frame;
  assign o_parity_err      = s_q.par_err;
  // RULE11: both pin groups alike
  assign o_trim1           = s_q.trim;
  assign o_trim2           = s_q.trim;
  assign o_irq             = s_q.irq;

endmodule

// file: txlt_regs_properties.sv
// Port-level checks for the tx length and trim register block
`timescale 1ns/100ps
module txlt_regs_properties (
  // Clock, reset and bus handshake
  input wire logic        i_clk,
  input wire logic        i_reset,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic        o_avs_waitrequest,
  // Commands and modes
  input wire logic        i_set_default,
  input wire logic        i_tx_start,
  input wire logic        i_iso14443a_mode,
  input wire logic        i_anticoll_enable,
  input wire logic        i_card_idle,
  input wire logic        i_wupa_cmd,
  input wire logic        i_cal_valid,
  // Watched outputs
  input wire logic [12:0] o_tx_byte_count,
  input wire logic [2:0]  o_tx_split_bits,
  input wire logic        o_tx_no_parity,
  input wire logic        o_tx_bit_frame,
  input wire logic        o_parity_err,
  input wire logic [3:0]  o_trim1,
  input wire logic [3:0]  o_trim2
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence bus_taken_s;
    (i_avs_read || i_avs_write) && o_avs_waitrequest;
  endsequence
  sequence bus_answer_s;
    !o_avs_waitrequest ##1 o_avs_waitrequest;
  endsequence

  bus_answer_a: assert property (
    bus_taken_s |=> bus_answer_s)
    else $error("bus access not answered after one wait cycle");
  frame_mode_a: assert property (
    i_tx_start |=> o_tx_bit_frame ==
      ($past(i_iso14443a_mode) && o_tx_split_bits != 3'h0))
    else $error("bit frame does not follow mode and split count");
  parity_pair_a: assert property (
    o_tx_no_parity == o_tx_bit_frame)
    else $error("parity suppression differs from bit frame");
  tx_hold_a: assert property (
    !i_tx_start && !i_set_default |=>
      $stable({o_tx_byte_count, o_tx_split_bits}))
    else $error("transmit counts moved without a start");
  parity_cause_a: assert property (
    o_parity_err |-> $past(i_wupa_cmd && i_anticoll_enable && i_card_idle))
    else $error("parity error without qualifying wakeup");
  parity_block_a: assert property (
    i_wupa_cmd && !(i_anticoll_enable && i_card_idle) |=> !o_parity_err)
    else $error("parity error outside idle anticollision");
  trim_pair_a: assert property (
    o_trim1 == o_trim2)
    else $error("trim pin groups differ");
  default_trim_a: assert property (
    i_set_default ##1 !i_cal_valid |=> o_trim1 == 4'h0)
    else $error("trim not cleared by restore defaults");
endmodule

bind txlt_regs txlt_regs_properties u_props (
  .i_clk, .i_reset, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .i_set_default, .i_tx_start, .i_iso14443a_mode, .i_anticoll_enable,
  .i_card_idle, .i_wupa_cmd, .i_cal_valid, .o_tx_byte_count,
  .o_tx_split_bits, .o_tx_no_parity, .o_tx_bit_frame, .o_parity_err,
  .o_trim1, .o_trim2
);

// file: test_txlt_regs.sv
// Self-checking bench for the tx length and antenna trim registers
`timescale 1ns/100ps
`include "txlt_map.svh"
module test_txlt_regs;
  logic        i_clk, i_reset, i_avs_read, i_avs_write;
  logic [7:0]  i_avs_address, i_adc_data, ad;
  logic [3:0]  i_avs_byteenable, i_rate_code, i_cal_trim, man;
  logic [31:0] i_avs_writedata, o_avs_readdata, q;
  logic        i_set_default, i_tx_start, i_iso14443a_mode;
  logic        i_anticoll_enable, i_card_idle, i_wupa_cmd;
  logic        i_rate_valid, i_adc_valid, i_cal_valid;
  logic        o_avs_waitrequest, o_tx_no_parity, o_tx_bit_frame;
  logic        o_parity_err, o_irq, fr;
  logic [12:0] o_tx_byte_count, cnt;
  logic [2:0]  o_tx_split_bits, spl;
  logic [3:0]  o_trim1, o_trim2;
  logic [5:0]  k;
  integer      seed;
  int          bad_count, cmp_count;

  txlt_regs dut (
    .i_clk, .i_reset, .i_avs_address, .i_avs_read, .i_avs_write,
    .i_avs_byteenable, .i_avs_writedata, .o_avs_readdata,
    .o_avs_waitrequest, .i_set_default, .i_tx_start, .i_iso14443a_mode,
    .i_anticoll_enable, .i_card_idle, .i_wupa_cmd, .i_rate_valid,
    .i_rate_code, .i_adc_valid, .i_adc_data, .i_cal_valid, .i_cal_trim,
    .o_tx_byte_count, .o_tx_split_bits, .o_tx_no_parity, .o_tx_bit_frame,
    .o_parity_err, .o_trim1, .o_trim2, .o_irq
  );

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  // Framing flag expected after a start: split byte in 14443A only
  function automatic logic exp_frame(input logic iso, input logic [2:0] s);
    return iso && (s != 3'h0);
  endfunction

  // Low count register image: count bits 4 to 0 over the split bits
  function automatic logic [31:0] exp_lo(input logic [12:0] c,
                                         input logic [2:0]  s);
    return {24'h0, c[4:0], s};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Holds the request until waitrequest is sampled low, then releases it
  task automatic bus(input logic wr, input logic [5:0] idx,
                     input logic [31:0] d);
    int n;
    n = 0;
    i_avs_address   <= {idx, 2'h0};
    i_avs_write     <= wr;
    i_avs_read      <= !wr;
    i_avs_writedata <= d;
    do begin
      @(posedge i_clk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    q = o_avs_readdata;
    i_avs_write <= 1'b0;
    i_avs_read  <= 1'b0;
    @(posedge i_clk);
    if (n >= 50) begin
      bad_count++;
      tally_and_finish();
    end
  endtask

  task automatic rd(input logic [5:0] idx, input logic [31:0] e,
                    input string nm);
    bus(1'b0, idx, 32'h0);
    chk(nm, e, q);
  endtask

  initial begin
    {i_avs_read, i_avs_write, i_set_default, i_tx_start, i_wupa_cmd} = '0;
    {i_rate_valid, i_adc_valid, i_cal_valid, i_anticoll_enable} = '0;
    {i_iso14443a_mode, i_card_idle} = '0;
    {i_avs_address, i_rate_code, i_adc_data, i_cal_trim} = '0;
    i_avs_byteenable = 4'hF;
    i_avs_writedata = 32'h0;
    seed = 32'hE1EF;
    bad_count = 0;
    cmp_count = 0;
    i_reset = 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    @(posedge i_clk);
    for (k = 6'h1D; k <= 6'h21; k++)
      rd(k, 32'h0, "reset value");
    $display("test reset done");
    for (int t = 0; t < 4; t++) begin
      cnt = (t == 0) ? 13'h1FFF : 13'($random(seed));
      spl = (t == 1) ? 3'h0 : 3'($random(seed));
      i_iso14443a_mode <= (t != 2);
      bus(1'b1, `TXLT_IDX_CNT_HI, {24'h0, cnt[12:5]});
      bus(1'b1, `TXLT_IDX_CNT_LO, exp_lo(cnt, spl));
      rd(`TXLT_IDX_CNT_HI, {24'h0, cnt[12:5]}, "count high");
      rd(`TXLT_IDX_CNT_LO, exp_lo(cnt, spl), "count low");
      i_tx_start <= 1'b1;
      @(posedge i_clk);
      i_tx_start <= 1'b0;
      @(posedge i_clk);
      chk("tx count", 32'(cnt), 32'(o_tx_byte_count));
      chk("tx split", 32'(spl), 32'(o_tx_split_bits));
      fr = exp_frame(t != 2, spl);
      chk("no parity", 32'(fr), 32'(o_tx_no_parity));
      chk("bit frame", 32'(fr), 32'(o_tx_bit_frame));
    end
    bus(1'b1, `TXLT_IDX_CNT_HI, 32'h0);
    chk("count held", 32'(cnt), 32'(o_tx_byte_count));
    $display("test transmit done");
    man = 4'($random(seed));
    ad = 8'($random(seed));
    i_rate_code <= man;
    i_adc_data <= ad;
    i_rate_valid <= 1'b1;
    i_adc_valid <= 1'b1;
    @(posedge i_clk);
    i_rate_valid <= 1'b0;
    i_adc_valid <= 1'b0;
    @(posedge i_clk);
    bus(1'b1, `TXLT_IDX_ADC, 32'h000000FF);
    rd(`TXLT_IDX_RATE, {24'h0, man, 4'h0}, "rate display");
    rd(`TXLT_IDX_ADC, {24'h0, ad}, "conversion");
    rd(6'h3F, 32'h0, "unmapped");
    $display("test results done");
    i_cal_trim <= man;
    i_cal_valid <= 1'b1;
    @(posedge i_clk);
    i_cal_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("cal trim", 32'(man), 32'(o_trim1));
    bus(1'b1, `TXLT_IDX_TUNE, {24'h0, 1'b1, ~man, 3'h7});
    chk("manual trim", {28'h0, ~man}, 32'(o_trim2));
    // Write with lane 0 disabled must leave the tuning control alone
    i_avs_byteenable <= 4'hE;
    bus(1'b1, `TXLT_IDX_TUNE, 32'h00000000);
    i_avs_byteenable <= 4'hF;
    rd(`TXLT_IDX_TUNE, {24'h0, 1'b1, ~man, 3'h0}, "tune");
    $display("test trim done");
    bus(1'b1, `TXLT_IDX_CNT_LO, 32'h00000005);
    bus(1'b1, `TXLT_IDX_IRQ_ENABLE, 32'h00000002);
    i_anticoll_enable <= 1'b1;
    i_card_idle <= 1'b1;
    i_wupa_cmd <= 1'b1;
    @(posedge i_clk);
    i_wupa_cmd <= 1'b0;
    @(posedge i_clk);
    chk("parity err", 32'h1, 32'(o_parity_err));
    chk("irq", 32'h1, 32'(o_irq));
    rd(`TXLT_IDX_IRQ_STATUS, 32'h0000000F, "status");
    bus(1'b1, `TXLT_IDX_IRQ_CLEAR, 32'h0000000F);
    i_card_idle <= 1'b0;
    i_wupa_cmd <= 1'b1;
    i_cal_valid <= 1'b1;
    @(posedge i_clk);
    {i_wupa_cmd, i_cal_valid} <= 2'h0;
    @(posedge i_clk);
    chk("irq masked", 32'h0, 32'(o_irq));
    rd(`TXLT_IDX_IRQ_STATUS, 32'h00000008, "status busy");
    $display("test interrupt done");
    i_set_default <= 1'b1;
    @(posedge i_clk);
    i_set_default <= 1'b0;
    repeat (2) @(posedge i_clk);
    chk("trim default", 32'h0, 32'(o_trim1));
    for (k = 6'h1D; k <= 6'h21; k++)
      rd(k, 32'h0, "default value");
    rd(`TXLT_IDX_IRQ_ENABLE, 32'h00000002, "enable kept");
    $display("test defaults done");
    tally_and_finish();
  end
endmodule
